// ==== rtl/insn_exec_pkg.sv ====
package insn_exec_pkg;

	// ==========================================================
	// Bus and storage geometry
	localparam int APB_ADDR_W = 12;
	localparam int APB_DATA_W = 32;
	localparam int RF_DEPTH   = 64;
	localparam int SFR_DEPTH  = 16;
	localparam int PM_ADDR_W  = 11;
	localparam int PM_DATA_W  = 14;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [APB_ADDR_W-1:0] OFF_CMD    = 12'h000;
	localparam logic [APB_ADDR_W-1:0] OFF_CTRL   = 12'h004;
	localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 12'h008;
	localparam logic [APB_ADDR_W-1:0] OFF_WORK   = 12'h00C;
	localparam logic [APB_ADDR_W-1:0] OFF_TABLE_HIGH_POINTER   = 12'h010;
	localparam logic [APB_ADDR_W-1:0] OFF_TABLE_HIGH_DATA   = 12'h014;
	localparam logic [APB_ADDR_W-1:0] OFF_WDOG   = 12'h018;
	localparam logic [APB_ADDR_W-1:0] SFR_BASE   = 12'h040;
	localparam logic [APB_ADDR_W-1:0] RF_BASE    = 12'h100;

	// ==========================================================
	// Command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_OPND_LSB = 8;
	localparam int CMD_DEST_BIT = 15;
	localparam int CMD_IMM_LSB  = 16;

	localparam logic [2:0] OP_LOAD_SPAGE = 3'h0;
	localparam logic [2:0] OP_READ_SPAGE = 3'h1;
	localparam logic [2:0] OP_HALT       = 3'h2;
	localparam logic [2:0] OP_SUB_REG    = 3'h3;
	localparam logic [2:0] OP_SUB_IMM    = 3'h4;
	localparam logic [2:0] OP_SWAP       = 3'h5;
	localparam logic [2:0] OP_TABLE      = 3'h6;

	// ==========================================================
	// Control and status fields
	localparam int CTRL_WDT_EN = 0;
	localparam int CTRL_WAKE   = 1;

	localparam int ST_CARRY   = 0;
	localparam int ST_HALF    = 1;
	localparam int ST_ZERO    = 2;
	localparam int ST_PDOWN   = 3;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_HALTED  = 5;
	localparam int ST_BUSY    = 6;

	localparam int WDOG_PRESC_LSB = 8;

	// ==========================================================
	// Reset values
	localparam logic [7:0] WORK_RST    = 8'h00;
	localparam logic [7:0] TABLE_HIGH_POINTER_RST    = 8'h00;
	localparam logic [5:0] TABLE_HIGH_DATA_RST    = 6'h00;
	localparam logic       TIMEOUT_RST = 1'b1;
	localparam logic       PDOWN_RST   = 1'b1;
	localparam logic       WDT_EN_RST  = 1'b0;

endpackage : insn_exec_pkg

// ==== rtl/insn_subset_exec.sv ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps

// ==========================================================
// Instruction subset execution unit with APB command port
// Behaviour
// - S-page load copies working register into selected SPECIAL_FUNCTION_REG, one cycle, no flags
// - S-page read copies selected SPECIAL_FUNCTION_REG into working register, source unchanged
// - Halt clears watchdog counter and watchdog divider to zero
// - Halt sets timeout flag, clears powerdown flag, other flags untouched
// - After halt executes the device stops executing instructions
// - Register subtract: reg minus work, flags Z DC C, dest selects target
// - Carry clear on borrow, set when no borrow, also for zero result
// - Immediate subtract: imm minus work into work, flags Z DC C
// - Nibble swap exchanges halves, result to work or register by dest
// - Table read address is table pointer bits 2:0 above work; low byte to work
// - Table read puts word bits 13:8 into table high data; two cycles
module insn_subset_exec #(
	parameter int PRESC_W = 8,
	parameter int WDT_W   = 8
) (
	input  wire logic                                 clk,
	input  wire logic                                 srst,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [insn_exec_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [insn_exec_pkg::APB_DATA_W-1:0] pwdata,
	output logic      [insn_exec_pkg::APB_DATA_W-1:0] prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	output logic      [insn_exec_pkg::PM_ADDR_W-1:0]  pmAddr,
	input  wire logic [insn_exec_pkg::PM_DATA_W-1:0]  pmData,
	output logic                                      haltMode
);
	import insn_exec_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TABLE} state_e;

	state_e                   state, next_state;
	logic [7:0]               rf [RF_DEPTH];
	logic [7:0]               special_function_reg [SFR_DEPTH];
	logic [7:0]               work, next_work;
	logic [7:0]               table_high_pointer, next_table_high_pointer;
	logic [5:0]               table_high_data, next_table_high_data;
	logic                     zero, next_zero;
	logic                     halfCarry, next_halfCarry;
	logic                     carry, next_carry;
	logic                     timeout, next_timeout;
	logic                     powerdown, next_powerdown;
	logic                     halted, next_halted;
	logic                     wdtEn, next_wdtEn;
	logic [2:0]               curOp, next_curOp;
	logic [5:0]               curOperand, next_curOperand;
	logic                     curDest, next_curDest;
	logic [7:0]               curImm, next_curImm;
	logic [PM_ADDR_W-1:0]     next_pmAddr;
	logic [PRESC_W-1:0]       presc, next_presc;
	logic [WDT_W-1:0]         wdt, next_wdt;
	logic                     next_pready, next_pslverr;
	logic [APB_DATA_W-1:0]    next_prdata, rdMux;
	logic                     addrOk, apbWr, haltExec, wdtWrap, opLegal;
	logic                     rfWe, sfrWe;
	logic [5:0]               rfWaddr;
	logic [3:0]               sfrWaddr;
	logic [7:0]               rfWdata, sfrWdata;
	logic [7:0]               subA, aluDiff, swapOut;
	logic                     aluZero, aluHalf, aluCarry;

	// ==========================================================
	// Datapath
	assign subA = (curOp == OP_SUB_IMM) ? curImm : rf[curOperand];

	sub_swap_unit u_alu (
		.minuend    (subA),
		.subtrahend (work),
		.diff       (aluDiff),
		.zeroOut    (aluZero),
		.halfOut    (aluHalf),
		.carryOut   (aluCarry),
		.swapped    (swapOut)
	);

	// ==========================================================
	// APB slave: one wait state, so read data is sampled while the core is idle
	assign apbWr    = psel && penable && pwrite && pready && !pslverr;
	assign haltMode = halted;
	assign opLegal  = (pwdata[CMD_OP_LSB +: 3] <= OP_TABLE);

	always_comb begin
		rdMux  = '0;
		addrOk = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			addrOk = 1'b0;
		end else if (paddr[11:6] == SFR_BASE[11:6]) begin
			rdMux[7:0] = special_function_reg[paddr[5:2]];
		end else if (paddr[11:8] == RF_BASE[11:8]) begin
			rdMux[7:0] = rf[paddr[7:2]];
		end else begin
			case (paddr)
				OFF_CMD: begin
					rdMux[CMD_OP_LSB +: 3]   = curOp;
					rdMux[CMD_OPND_LSB +: 6] = curOperand;
					rdMux[CMD_DEST_BIT]      = curDest;
					rdMux[CMD_IMM_LSB +: 8]  = curImm;
				end
				OFF_CTRL:   rdMux[CTRL_WDT_EN] = wdtEn;
				OFF_STATUS: begin
					rdMux[ST_CARRY]   = carry;
					rdMux[ST_HALF]    = halfCarry;
					rdMux[ST_ZERO]    = zero;
					rdMux[ST_PDOWN]   = powerdown;
					rdMux[ST_TIMEOUT] = timeout;
					rdMux[ST_HALTED]  = halted;
					rdMux[ST_BUSY]    = (state != ST_IDLE);
				end
				OFF_WORK:   rdMux[7:0] = work;
				OFF_TABLE_HIGH_POINTER:   rdMux[7:0] = table_high_pointer;
				OFF_TABLE_HIGH_DATA:   rdMux[5:0] = table_high_data;
				OFF_WDOG: begin
					rdMux[WDT_W-1:0]                   = wdt;
					rdMux[WDOG_PRESC_LSB +: PRESC_W] = presc;
				end
				default:    addrOk = 1'b0;
			endcase
		end
	end

	// Access completes only from idle; a busy core stretches the access phase
	always_comb begin
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_prdata  = prdata;
		if (psel && penable && !pready && state == ST_IDLE) begin
			next_pready  = 1'b1;
			next_pslverr = !addrOk;
			next_prdata  = rdMux;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ==========================================================
	// Watchdog counter and divider
	assign wdtWrap = wdtEn && (presc == '1) && (wdt == '1);

	always_comb begin
		next_presc = presc;
		next_wdt   = wdt;
		if (haltExec) begin
			next_presc = '0;
			next_wdt   = '0;
		end else if (wdtEn) begin
			next_presc = PRESC_W'(presc + 1'b1);
			if (presc == '1) begin
				next_wdt = WDT_W'(wdt + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			presc <= '0;
			wdt   <= '0;
		end else begin
			presc <= next_presc;
			wdt   <= next_wdt;
		end
	end

	// ==========================================================
	// Instruction sequencer
	always_comb begin
		next_state      = state;
		next_work       = work;
		next_table_high_pointer       = table_high_pointer;
		next_table_high_data       = table_high_data;
		next_zero       = zero;
		next_halfCarry  = halfCarry;
		next_carry      = carry;
		next_timeout    = timeout;
		next_powerdown  = powerdown;
		next_halted     = halted;
		next_wdtEn      = wdtEn;
		next_curOp      = curOp;
		next_curOperand = curOperand;
		next_curDest    = curDest;
		next_curImm     = curImm;
		next_pmAddr     = pmAddr;
		haltExec        = 1'b0;
		rfWe            = 1'b0;
		rfWaddr         = paddr[7:2];
		rfWdata         = pwdata[7:0];
		sfrWe           = 1'b0;
		sfrWaddr        = paddr[5:2];
		sfrWdata        = pwdata[7:0];
		unique case (state)
			ST_IDLE: begin
				if (apbWr && paddr[11:6] == SFR_BASE[11:6]) begin
					sfrWe = 1'b1;
				end
				if (apbWr && paddr[11:8] == RF_BASE[11:8]) begin
					rfWe = 1'b1;
				end
				if (apbWr && paddr == OFF_WORK) begin
					next_work = pwdata[7:0];
				end
				if (apbWr && paddr == OFF_TABLE_HIGH_POINTER) begin
					next_table_high_pointer = pwdata[7:0];
				end
				if (apbWr && paddr == OFF_CTRL) begin
					next_wdtEn = pwdata[CTRL_WDT_EN];
					if (pwdata[CTRL_WAKE]) begin
						next_halted = 1'b0;
					end
				end
				// A halted core ignores commands until woken
				if (apbWr && paddr == OFF_CMD && !halted && opLegal) begin
					next_curOp      = pwdata[CMD_OP_LSB +: 3];
					next_curOperand = pwdata[CMD_OPND_LSB +: 6];
					next_curDest    = pwdata[CMD_DEST_BIT];
					next_curImm     = pwdata[CMD_IMM_LSB +: 8];
					next_pmAddr     = {table_high_pointer[2:0], work};
					next_state      = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state = ST_IDLE;
				rfWaddr    = curOperand;
				sfrWaddr   = curOperand[3:0];
				sfrWdata   = work;
				unique case (curOp)
					OP_LOAD_SPAGE: sfrWe = 1'b1;
					OP_READ_SPAGE: next_work = special_function_reg[curOperand[3:0]];
					OP_HALT: begin
						haltExec       = 1'b1;
						next_timeout   = 1'b1;
						next_powerdown = 1'b0;
						next_halted    = 1'b1;
					end
					OP_SUB_REG, OP_SUB_IMM: begin
						next_zero      = aluZero;
						next_halfCarry = aluHalf;
						next_carry     = aluCarry;
						rfWdata        = aluDiff;
						if (curDest && curOp == OP_SUB_REG) begin
							rfWe = 1'b1;
						end else begin
							next_work = aluDiff;
						end
					end
					OP_SWAP: begin
						rfWdata = swapOut;
						if (curDest) begin
							rfWe = 1'b1;
						end else begin
							next_work = swapOut;
						end
					end
					default: next_state = ST_TABLE;
				endcase
			end
			ST_TABLE: begin
				next_work  = pmData[7:0];
				next_table_high_data  = pmData[13:8];
				next_state = ST_IDLE;
			end
		endcase
		// Watchdog expiry wakes the core and marks a timeout; a halt in the same cycle wins
		if (wdtWrap && !haltExec) begin
			next_timeout = 1'b0;
			next_halted  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state      <= ST_IDLE;
			work       <= WORK_RST;
			table_high_pointer       <= TABLE_HIGH_POINTER_RST;
			table_high_data       <= TABLE_HIGH_DATA_RST;
			zero       <= 1'b0;
			halfCarry  <= 1'b0;
			carry      <= 1'b0;
			timeout    <= TIMEOUT_RST;
			powerdown  <= PDOWN_RST;
			halted     <= 1'b0;
			wdtEn      <= WDT_EN_RST;
			curOp      <= OP_LOAD_SPAGE;
			curOperand <= '0;
			curDest    <= 1'b0;
			curImm     <= 8'h00;
			pmAddr     <= '0;
		end else begin
			state      <= next_state;
			work       <= next_work;
			table_high_pointer       <= next_table_high_pointer;
			table_high_data       <= next_table_high_data;
			zero       <= next_zero;
			halfCarry  <= next_halfCarry;
			carry      <= next_carry;
			timeout    <= next_timeout;
			powerdown  <= next_powerdown;
			halted     <= next_halted;
			wdtEn      <= next_wdtEn;
			curOp      <= next_curOp;
			curOperand <= next_curOperand;
			curDest    <= next_curDest;
			curImm     <= next_curImm;
			pmAddr     <= next_pmAddr;
		end
	end

	// Storage arrays carry no reset, as in a real register file
	always_ff @(posedge clk) begin
		if (rfWe) begin
			rf[rfWaddr] <= rfWdata;
		end
		if (sfrWe) begin
			special_function_reg[sfrWaddr] <= sfrWdata;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic execNow;
	assign execNow = (state == ST_EXEC);

	chk_spage_load: assert property (execNow && curOp == OP_LOAD_SPAGE |=>
		special_function_reg[$past(curOperand[3:0])] == $past(work) && carry == $past(carry) && zero == $past(zero))
		else $error("S-page load did not copy working register");
	chk_spage_read: assert property (execNow && curOp == OP_READ_SPAGE |=>
		work == $past(special_function_reg[curOperand[3:0]]) && special_function_reg[$past(curOperand[3:0])] == $past(special_function_reg[curOperand[3:0]]))
		else $error("S-page read result wrong");
	chk_halt_wdog: assert property (execNow && curOp == OP_HALT |=> wdt == '0 && presc == '0)
		else $error("Halt did not clear watchdog");
	chk_halt_flags: assert property (execNow && curOp == OP_HALT |=>
		timeout && !powerdown && carry == $past(carry) && zero == $past(zero) && halfCarry == $past(halfCarry))
		else $error("Halt flag update wrong");
	chk_halt_stops: assert property (halted && state == ST_IDLE |=> state == ST_IDLE)
		else $error("Halted core started a command");
	chk_sub_reg: assert property (execNow && curOp == OP_SUB_REG && curDest |=>
		rf[$past(curOperand)] == 8'($past(rf[curOperand]) - $past(work)) && zero == (rf[$past(curOperand)] == 8'h00))
		else $error("Register subtract result wrong");
	chk_sub_carry: assert property (execNow && (curOp == OP_SUB_REG || curOp == OP_SUB_IMM) |=>
		carry == ($past(subA) >= $past(work)))
		else $error("Subtract carry wrong");
	chk_sub_imm: assert property (execNow && curOp == OP_SUB_IMM |=> work == 8'($past(curImm) - $past(work)))
		else $error("Immediate subtract result wrong");
	chk_swap_work: assert property (execNow && curOp == OP_SWAP && !curDest |=>
		work == {$past(rf[curOperand][3:0]), $past(rf[curOperand][7:4])})
		else $error("Nibble swap result wrong");
	chk_table_addr: assert property (execNow && curOp == OP_TABLE |-> pmAddr == {table_high_pointer[2:0], work})
		else $error("Table address wrong");
	chk_table_two: assert property (execNow && curOp == OP_TABLE |=> state == ST_TABLE ##1
		(state == ST_IDLE && table_high_data == $past(pmData[13:8]) && work == $past(pmData[7:0])))
		else $error("Table read not completed in two cycles");
	chk_half_carry: assert property (execNow && (curOp == OP_SUB_REG || curOp == OP_SUB_IMM) |=>
		halfCarry == ($past(subA[3:0]) >= $past(work[3:0])))
		else $error("Subtract half carry wrong");

	cov_halt: cover property (execNow && curOp == OP_HALT);
	cov_table: cover property (state == ST_TABLE);
	cov_sub_zero: cover property (execNow && curOp == OP_SUB_REG && aluZero);
	cov_wake: cover property (halted ##1 !halted);

endmodule : insn_subset_exec

// ==== rtl/sub_swap_unit.sv ====
`timescale 1ns/100ps

// ==========================================================
// Subtract and nibble swap datapath
module sub_swap_unit (
	input  wire logic [7:0] minuend,
	input  wire logic [7:0] subtrahend,
	output logic      [7:0] diff,
	output logic            zeroOut,
	output logic            halfOut,
	output logic            carryOut,
	output logic      [7:0] swapped
);
	logic [8:0] fullSum;
	logic [4:0] lowSum;

	// Two's complement add of the inverted subtrahend; carry out means no borrow
	always_comb begin
		fullSum  = 9'({1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001);
		lowSum   = 5'({1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01);
		diff     = fullSum[7:0];
		zeroOut  = (fullSum[7:0] == 8'h00);
		carryOut = fullSum[8];
		halfOut  = lowSum[4];
		swapped  = {minuend[3:0], minuend[7:4]};
	end

endmodule : sub_swap_unit

// ==== verification/insn_subset_exec_test.sv ====
`timescale 1ns/100ps

module insn_subset_exec_test;
	import insn_exec_pkg::*;

	// Short watchdog widths so a full wrap takes 64 clocks
	localparam int         PW        = 3;
	localparam int         WW        = 3;
	localparam logic [7:0] RVALS [5] = '{8'h05, 8'h06, 8'h06, 8'h10, 8'h80};
	localparam logic [7:0] WVALS [5] = '{8'h06, 8'h05, 8'h06, 8'h01, 8'h7F};

	logic                  clk;
	logic                  srst;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [APB_ADDR_W-1:0] paddr;
	logic [APB_DATA_W-1:0] pwdata;
	logic [APB_DATA_W-1:0] prdata;
	logic                  pready;
	logic                  pslverr;
	logic [PM_ADDR_W-1:0]  pmAddr;
	logic [PM_DATA_W-1:0]  pmData;
	logic                  haltMode;
	int                    failures;
	int                    num_checks;

	insn_subset_exec #(.PRESC_W(PW), .WDT_W(WW)) i_insn_subset_exec (
		.clk      (clk),
		.srst     (srst),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.pmAddr   (pmAddr),
		.pmData   (pmData),
		.haltMode (haltMode)
	);

	// ==========================================================
	// Clock and program memory
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [13:0] romWord(input logic [10:0] a);
		if (a == 11'h234)
			return 14'h35AA;
		return {a[5:0] ^ 6'h15, a[10:3] ^ 8'hC3};
	endfunction : romWord

	// Registered lookup: address settles two clocks before the word is sampled
	always @(posedge clk) begin
		pmData <= romWord(pmAddr);
	end

	// ==========================================================
	// Bus tasks and comparison
	task automatic end_sim();
		$display("Comparisons: %0d  mismatches: %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [11:0] where);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: addr %h got %h expected %h", $time, where, got, exp);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			failures++;
			$display("MISMATCH at %0t: no bus answer at %h", $time, a);
		end
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		xfer(1'b0, a, 32'h0, q, e);
		check(q, exp, a);
	endtask : rdChk

	task automatic cmd(input logic [2:0] op, input logic [5:0] opnd, input logic dest, input logic [7:0] imm);
		wr(OFF_CMD, {8'h00, imm, dest, 1'b0, opnd, 5'h00, op});
	endtask : cmd

	// ==========================================================
	// Tests
	initial begin
		logic [31:0] q;
		logic        e;
		logic [7:0]  r;
		logic [7:0]  w;
		logic [7:0]  df;
		int          i;
		int          m;
		srst       = 1'b1;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = '0;
		pwdata     = '0;
		failures   = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		rdChk(OFF_STATUS, 32'h18);
		rdChk(OFF_WORK, 32'h0);
		rdChk(OFF_TABLE_HIGH_DATA, 32'h0);
		rdChk(OFF_WDOG, 32'h0);
		for (i = 0; i < 5; i++) begin
			for (m = 0; m < 3; m++) begin
				r  = RVALS[i];
				w  = WVALS[i];
				df = r - w;
				wr(RF_BASE + 12'h0FC, {24'h0, r});
				wr(OFF_WORK, {24'h0, w});
				if (m == 2)
					cmd(OP_SUB_IMM, 6'h00, 1'b1, r);
				else
					cmd(OP_SUB_REG, 6'd63, m[0], 8'h00);
				rdChk(OFF_WORK, {24'h0, (m == 1) ? w : df});
				rdChk(RF_BASE + 12'h0FC, {24'h0, (m == 1) ? df : r});
				rdChk(OFF_STATUS, {29'h3, df == 8'h00, r[3:0] >= w[3:0], r >= w});
			end
		end
		for (i = 0; i < 16; i += 5) begin
			wr(OFF_WORK, 32'hA0 + i);
			cmd(OP_LOAD_SPAGE, 6'(i), 1'b0, 8'h00);
			rdChk(SFR_BASE + 12'(4 * i), 32'hA0 + i);
		end
		rdChk(OFF_STATUS, 32'h19);
		wr(SFR_BASE + 12'h014, 32'h55);
		wr(OFF_WORK, 32'hAA);
		cmd(OP_READ_SPAGE, 6'h05, 1'b0, 8'h00);
		rdChk(OFF_WORK, 32'h55);
		rdChk(SFR_BASE + 12'h014, 32'h55);
		wr(RF_BASE + 12'h008, 32'hA5);
		cmd(OP_SWAP, 6'h02, 1'b1, 8'h00);
		rdChk(RF_BASE + 12'h008, 32'h5A);
		cmd(OP_SWAP, 6'h02, 1'b0, 8'h00);
		rdChk(OFF_WORK, 32'hA5);
		// Pointer bits above 2 must not reach the address
		wr(OFF_TABLE_HIGH_POINTER, 32'hFA);
		wr(OFF_WORK, 32'h34);
		cmd(OP_TABLE, 6'h00, 1'b0, 8'h00);
		rdChk(OFF_WORK, 32'hAA);
		rdChk(OFF_TABLE_HIGH_DATA, 32'h35);
		check({21'h0, pmAddr}, 32'h234, OFF_CMD);
		cmd(OP_TABLE, 6'h00, 1'b0, 8'h00);
		rdChk(OFF_WORK, 32'h96);
		rdChk(OFF_TABLE_HIGH_DATA, 32'h3F);
		rdChk(OFF_TABLE_HIGH_POINTER, 32'hFA);
		xfer(1'b0, 12'h020, 32'h0, q, e);
		check({31'h0, e}, 32'h1, 12'h020);
		xfer(1'b1, 12'h00E, 32'h0, q, e);
		check({31'h0, e}, 32'h1, 12'h00E);
		// Let the watchdog wrap so the timeout flag drops first
		wr(OFF_CTRL, 32'h1);
		repeat (80) @(posedge clk);
		xfer(1'b0, OFF_STATUS, 32'h0, q, e);
		check(q & 32'h18, 32'h08, OFF_STATUS);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_WORK, 32'h06);
		cmd(OP_SUB_IMM, 6'h00, 1'b0, 8'h06);
		cmd(OP_HALT, 6'h00, 1'b0, 8'h00);
		rdChk(OFF_WDOG, 32'h0);
		rdChk(OFF_STATUS, 32'h37);
		check({31'h0, haltMode}, 32'h1, OFF_STATUS);
		cmd(OP_SUB_IMM, 6'h00, 1'b0, 8'h80);
		rdChk(OFF_WORK, 32'h00);
		wr(OFF_CTRL, 32'h2);
		rdChk(OFF_CTRL, 32'h0);
		rdChk(OFF_STATUS, 32'h17);
		check({31'h0, haltMode}, 32'h0, OFF_CTRL);
		end_sim();
	end

	initial begin
		#40000;
		failures++;
		$display("MISMATCH at %0t: run did not finish in time", $time);
		end_sim();
	end

endmodule : insn_subset_exec_test
